//--- verilog/tdct_pkg.sv
`default_nettype none
package tdct_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h020;
  localparam logic [11:0] ADDR_CTRL_SET = 12'h024;
  localparam logic [11:0] ADDR_CTRL_CLR = 12'h028;
  localparam logic [11:0] ADDR_CTRL_TOG = 12'h02C;
  localparam logic [11:0] ADDR_COUNT = 12'h030;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h040;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h044;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h048;
  // control field positions
  localparam int IRQ_FLAG_BIT = 15;
  localparam int IRQ_EN_BIT = 14;
  localparam int POLARITY_BIT = 8;
  localparam int LOAD_TOGETHER_BIT = 7;
  localparam int RELOAD_BIT = 6;
  localparam int DIV_LSB = 4;
  localparam int SRC_LSB = 0;
  // writable control bits; reserved fields read zero
  localparam logic [31:0] CTRL_WMASK = 32'h0000_C1FF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // tick source codes
  localparam logic [3:0] SRC_NEVER = 4'h0;
  localparam logic [3:0] SRC_PWM0 = 4'h1;
  localparam logic [3:0] SRC_PWM4 = 4'h5;
  localparam logic [3:0] SRC_QUAD_A = 4'h6;
  localparam logic [3:0] SRC_QUAD_B = 4'h7;
  localparam logic [3:0] SRC_XTAL = 4'h8;
  localparam logic [3:0] SRC_XTAL_8K = 4'h9;
  localparam logic [3:0] SRC_XTAL_4K = 4'hA;
  localparam logic [3:0] SRC_XTAL_1K = 4'hB;
  localparam logic [1:0] DIVIDE_BY_EIGHT_CODE = 2'h3;
  // slow crystal sub-dividers, counted in crystal edges
  localparam int XTAL_DIV_8K = 4;
  localparam int XTAL_DIV_4K = 8;
  localparam int XTAL_DIV_1K = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tdct_pkg
`default_nettype wire

//--- verilog/tdct_timer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE1) count decrementing to zero sets flag bit 15
// (RULE2) flag clears on written zero or clear alias
// (RULE3) enable bit 14 gates interrupt request
// (RULE4) polarity bit 8 picks rising or falling edge
// (RULE5) load-together bit 7 copies fixed into running
// (RULE6) reload bit set reloads running count at zero
// (RULE7) reload clear freezes count at zero
// (RULE8) fixed zero with reload keeps reloading
// (RULE9) clock_divider_select bits 5:4 divide by 1,2,4,8
// (RULE10) source bits 3:0 select tick input
// (RULE11) each tick decrements running count once
// (RULE12) undefined source code ticks every cycle; here it ticks on each prescaled enable, so every cycle only at divide by 1
// (RULE13) software writes zeros to reserved bits
// (RULE14) codes 9..11 select 8k, 4k, 1k crystal
// (RULE15) one detected edge gives one decrement
module tdct_timer #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [4:0] pwmOut,
  input wire logic quadratureInputA,
  input wire logic quadratureInputB,
  input wire logic slowCrystalTick,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import tdct_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [7:0] syncA;
  logic [7:0] syncB;
  wire [7:0] rawIn = {slowCrystalTick, quadratureInputB, quadratureInputA,
                      pwmOut};
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  // ==========================================================
  // registers
  logic [31:0] ctrl;
  logic [COUNT_WIDTH-1:0] fixedCount;
  logic [COUNT_WIDTH-1:0] runCount;
  logic zeroStatus;
  logic zeroEnable;

  wire [3:0] srcSel = ctrl[SRC_LSB +: 4];
  wire [1:0] divSel = ctrl[DIV_LSB +: 2];
  wire invertIn = ctrl[POLARITY_BIT];
  wire loadTogether = ctrl[LOAD_TOGETHER_BIT];
  wire reloadOn = ctrl[RELOAD_BIT];

  // ==========================================================
  // prescaler
  logic [2:0] preCnt;
  wire [2:0] divMask = 3'((4'h1 << divSel) - 4'h1); // RULE9
  wire preTick = ((preCnt & divMask) == 3'h0); // RULE9
  always_ff @(posedge ref_clk) begin
    if (!rstn) preCnt <= 3'h0;
    else preCnt <= preCnt + 3'h1;
  end

  // ==========================================================
  // slow crystal sub-divider, one shared edge counter tapped for each derived rate
  logic xtalPrev;
  logic [4:0] xtalDiv;
  wire xtalRise = syncB[7] & ~xtalPrev;
  wire [4:0] xtalNext = xtalDiv + 5'h1;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      xtalPrev <= 1'b0;
      xtalDiv <= 5'h00;
    end else begin
      xtalPrev <= syncB[7];
      if (xtalRise) xtalDiv <= xtalNext;
    end
  end
  // divided levels toggle at half period
  wire xtal8k = xtalDiv[$clog2(XTAL_DIV_8K)-1];
  wire xtal4k = xtalDiv[$clog2(XTAL_DIV_4K)-1];
  wire xtal1k = xtalDiv[$clog2(XTAL_DIV_1K)-1];

  // ==========================================================
  // source select and edge detection
  wire srcDefined = (srcSel <= SRC_XTAL_1K);
  logic srcLevel;
  always_comb begin
    srcLevel = 1'b0;
    if (srcSel >= SRC_PWM0 && srcSel <= SRC_PWM4)
      srcLevel = syncB[3'(srcSel - SRC_PWM0)]; // RULE10
    else if (srcSel == SRC_QUAD_A) srcLevel = syncB[5];
    else if (srcSel == SRC_QUAD_B) srcLevel = syncB[6];
    else if (srcSel == SRC_XTAL) srcLevel = syncB[7];
    else if (srcSel == SRC_XTAL_8K) srcLevel = xtal8k; // RULE14
    else if (srcSel == SRC_XTAL_4K) srcLevel = xtal4k; // RULE14
    else if (srcSel == SRC_XTAL_1K) srcLevel = xtal1k; // RULE14
  end
  wire edgeIn = srcLevel ^ invertIn; // RULE4
  logic edgePrev;
  logic edgePend;
  // edge is held pending until the next prescaled enable
  wire edgeSeen = edgeIn & ~edgePrev; // RULE4
  wire edgeTick = preTick & (edgePend | edgeSeen); // RULE15
  wire tick = (srcSel != SRC_NEVER) &&
              (srcDefined ? edgeTick : preTick); // RULE12
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      edgePrev <= 1'b0;
      edgePend <= 1'b0;
    end else begin
      edgePrev <= edgeIn;
      edgePend <= ~preTick & (edgePend | edgeSeen); // RULE15
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire haveAw = awHeld | awTake;
  wire haveW = wHeld | wTake;
  wire doWrite = haveAw & haveW;
  wire [11:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
  wire [3:0] wrStrb = wHeld ? wStrb : s_axi_wstrb;
  wire [31:0] byteMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}},
                          {8{wrStrb[1]}}, {8{wrStrb[0]}}};
  wire [31:0] wrBits = wrData & byteMask;
  wire [11:0] wordAddr = {wrAddr[11:2], 2'b00};
  wire wrCtrl = doWrite && wordAddr == ADDR_CTRL;
  wire wrSet = doWrite && wordAddr == ADDR_CTRL_SET;
  wire wrClr = doWrite && wordAddr == ADDR_CTRL_CLR;
  wire wrTog = doWrite && wordAddr == ADDR_CTRL_TOG;
  wire wrCount = doWrite && wordAddr == ADDR_COUNT;
  wire wrIrqEn = doWrite && wordAddr == ADDR_IRQ_ENABLE;
  wire wrIrqClr = doWrite && wordAddr == ADDR_IRQ_CLEAR;
  wire wrMapped = wrCtrl | wrSet | wrClr | wrTog | wrCount | wrIrqEn |
                  wrIrqClr | (doWrite && wordAddr == ADDR_IRQ_STATUS);

  // control update; reserved bits kept zero whatever is written RULE13
  logic [31:0] ctrlWr;
  always_comb begin
    ctrlWr = ctrl;
    if (wrCtrl) ctrlWr = (ctrl & ~byteMask) | wrBits;
    else if (wrSet) ctrlWr = ctrl | wrBits;
    else if (wrClr) ctrlWr = ctrl & ~wrBits;
    else if (wrTog) ctrlWr = ctrl ^ wrBits;
    ctrlWr = ctrlWr & CTRL_WMASK;
  end

  // ==========================================================
  // counter
  wire atOne = (runCount == COUNT_WIDTH'(1));
  wire atZero = (runCount == '0);
  wire decToZero = tick & atOne; // RULE1
  wire [COUNT_WIDTH-1:0] newFixed = wrBits[COUNT_WIDTH-1:0];
  logic [COUNT_WIDTH-1:0] next_runCount;
  always_comb begin
    next_runCount = runCount;
    if (wrCount && loadTogether && wrStrb[0])
      next_runCount = newFixed; // RULE5
    else if (atZero && reloadOn)
      next_runCount = fixedCount; // RULE8
    else if (tick && !atZero)
      next_runCount = runCount - COUNT_WIDTH'(1); // RULE11 RULE7
    if (decToZero && reloadOn && !(wrCount && loadTogether))
      next_runCount = fixedCount; // RULE6
  end

  // status flag: a set in the same cycle beats any clear
  wire flagClear = (wrCtrl | wrClr) & ~ctrlWr[IRQ_FLAG_BIT] |
                   wrTog & ctrl[IRQ_FLAG_BIT] & ~ctrlWr[IRQ_FLAG_BIT] |
                   wrIrqClr & wrBits[0]; // RULE2
  wire flagNext = decToZero | (ctrl[IRQ_FLAG_BIT] & ~flagClear); // RULE1

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      fixedCount <= COUNT_RESET;
      runCount <= COUNT_RESET;
      zeroEnable <= 1'b0;
    end else begin
      ctrl <= {ctrlWr[31:16], flagNext, ctrlWr[14:0]};
      runCount <= next_runCount;
      if (wrCount) fixedCount <= (fixedCount & ~byteMask[15:0]) | newFixed;
      if (wrIrqEn) zeroEnable <= wrBits[0];
    end
  end
  assign zeroStatus = ctrl[IRQ_FLAG_BIT];

  // interrupt needs both the control enable and the mask register
  assign irq = zeroStatus & ctrl[IRQ_EN_BIT] & zeroEnable; // RULE3

  // write handshake
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld <= 1'b1;
          awAddr <= s_axi_awaddr;
        end
        if (wTake) begin
          wHeld <= 1'b1;
          wData <= s_axi_wdata;
          wStrb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = ~s_axi_rvalid;
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire [11:0] rdAddr = {s_axi_araddr[11:2], 2'b00};
  wire [31:0] countWord = {runCount, fixedCount};
  wire rdCtrlAny = rdAddr == ADDR_CTRL || rdAddr == ADDR_CTRL_SET ||
                   rdAddr == ADDR_CTRL_CLR || rdAddr == ADDR_CTRL_TOG;
  wire rdOk = rdCtrlAny || rdAddr == ADDR_COUNT ||
              rdAddr == ADDR_IRQ_STATUS || rdAddr == ADDR_IRQ_ENABLE ||
              rdAddr == ADDR_IRQ_CLEAR;
  wire [31:0] rdMux =
    rdCtrlAny ? ctrl :
    rdAddr == ADDR_COUNT ? countWord :
    rdAddr == ADDR_IRQ_STATUS ? {31'h0000_0000, zeroStatus} :
    rdAddr == ADDR_IRQ_ENABLE ? {31'h0000_0000, zeroEnable} :
    32'h0000_0000;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : tdct_timer
`default_nettype wire

//--- tb/tdct_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bus handshake and interrupt checks
module tdct_props
  import tdct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  wire logic rTake = s_axi_arvalid && s_axi_arready;
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_answer: assert property (wTake |=> s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (rTake |=> s_axi_rvalid)
    else $error("no read response");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while busy");
  a_rd_unmapped: assert property (rTake && s_axi_araddr == 12'h100 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read");
  a_wr_unmapped: assert property (wTake && s_axi_awaddr == 12'h100 |=>
    s_axi_bresp == RESP_SLVERR) else $error("unmapped write");
  a_ctrl_reserved: assert property (
    rTake && s_axi_araddr == ADDR_CTRL |=>
    s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[13:9] == 5'h0)
    else $error("reserved bits set");
  a_irq_flag: assert property (
    rTake && s_axi_araddr == ADDR_IRQ_STATUS && irq && !s_axi_wvalid |=>
    s_axi_rdata[0]) else $error("irq no flag");
endmodule : tdct_props
bind tdct_timer tdct_props i_props (.ref_clk, .rstn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

//--- tb/tdct_tick_sources.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// tick sources: selected pwm or quadrature line follows lvl, code 0 drives all of those lines
module tdct_tick_sources #(
  parameter int XTAL_HALF_NS = 15625
) (
  input wire logic [3:0] srcCode,
  input wire logic lvl,
  output logic [4:0] pwmOut,
  output logic quadratureInputA,
  output logic quadratureInputB,
  output var logic slowCrystalTick
);
  for (genvar i = 0; i < 5; i++) begin : g_pwm
    assign pwmOut[i] = lvl && (srcCode == 4'(i + 1) || srcCode == 4'h0);
  end
  assign quadratureInputA = lvl && (srcCode inside {4'h0, 4'h6});
  assign quadratureInputB = lvl && (srcCode inside {4'h0, 4'h7});
  // crystal runs free, it never stops between uses
  initial begin
    slowCrystalTick = 1'b0;
    forever #(XTAL_HALF_NS) slowCrystalTick = ~slowCrystalTick;
  end
endmodule : tdct_tick_sources
`default_nettype wire

//--- tb/tdct_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// timer bench
module tdct_timer_tb;
  import tdct_pkg::*;
  localparam logic [31:0] LD = 32'h80, RL = 32'h40, IE = 32'h4000;
  logic ref_clk = 1'b0, rstn = 1'b0, lvl = 1'b0, awv = 1'b0, wv = 1'b0;
  logic br = 1'b0, arv = 1'b0, rr = 1'b0, awr, wrd, bv, arr, rv, irq;
  logic qa, qb, xt;
  logic [4:0] pwm;
  logic [3:0] src = 4'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [1:0] bresp, rresp, lastResp;
  int errorCnt = 0, totalChecks = 0, cyc = 0, stamp;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  tdct_tick_sources i_src (.srcCode(src), .lvl(lvl), .pwmOut(pwm),
    .quadratureInputA(qa), .quadratureInputB(qb), .slowCrystalTick(xt));
  tdct_timer i_dut (.ref_clk(ref_clk), .rstn(rstn), .pwmOut(pwm),
    .quadratureInputA(qa), .quadratureInputB(qb), .slowCrystalTick(xt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .irq(irq));
  task automatic closeOut();
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : closeOut
  task automatic fail();
    errorCnt++;
    $display("Error at %0t: timeout", $time);
    closeOut();
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // ready raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (n == 2) br <= 1'b1;
    end while (!(bv && br) && n < 50);
    lastResp = bresp;
    br <= 1'b0;
    if (n >= 50) fail();
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arr) arv <= 1'b0;
      if (n == 2) rr <= 1'b1;
    end while (!(rv && rr) && n < 50);
    rdv = rdata;
    lastResp = rresp;
    stamp = cyc;
    rr <= 1'b0;
    if (n >= 50) fail();
  endtask : rd
  task automatic cnt(input logic [15:0] e);
    rd(ADDR_COUNT);
    chk({16'h0, rdv[31:16]}, {16'h0, e});
  endtask : cnt
  task automatic setup(input logic [31:0] c, input logic [15:0] f);
    wr(ADDR_CTRL, c);
    repeat (8) @(posedge ref_clk);
    wr(ADDR_COUNT, {16'h0, f});
  endtask : setup
  task automatic pulse(input int k);
    repeat (k) begin
      lvl <= 1'b1;
      repeat (8) @(posedge ref_clk);
      lvl <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask : pulse
  task automatic tBasic();
    rd(ADDR_CTRL);
    chk(rdv, CTRL_RESET);
    cnt(COUNT_RESET);
    rd(12'h100);
    chk({30'h0, lastResp}, {30'h0, RESP_SLVERR});
    wr(12'h100, 32'hFFFF);
    chk({30'h0, lastResp}, {30'h0, RESP_SLVERR});
    for (int c = 0; c < 8; c++) begin
      src <= 4'(c);
      setup(LD | 32'(c), 16'h3);
      pulse(1);
      cnt(c == 0 ? 16'h3 : 16'h2);
    end
    src <= SRC_PWM0;
    setup(32'h101 | LD, 16'h5);
    lvl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cnt(16'h5);
    lvl <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cnt(16'h4);
    $display("sources done");
  endtask : tBasic
  task automatic tIrq();
    wr(ADDR_IRQ_ENABLE, 32'h1);
    setup(32'h1 | LD | RL | IE, 16'h2);
    pulse(2);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_IRQ_STATUS);
    chk(rdv, 32'h1);
    cnt(16'h2);
    wr(ADDR_CTRL, 32'h1 | LD | RL | IE);
    chk({31'h0, irq}, 32'h0);
    pulse(2);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_CTRL_CLR, 32'h8000);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_CTRL, 32'h1 | RL);
    pulse(2);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_CTRL);
    chk(rdv, 32'h8041);
    $display("irq done");
  endtask : tIrq
  task automatic tReload();
    logic [31:0] r0, t0, e;
    setup(32'h1 | LD, 16'h1);
    pulse(3);
    cnt(16'h0);
    wr(ADDR_COUNT, 32'h7);
    cnt(16'h7);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, 32'h1 | RL);
    wr(ADDR_COUNT, 32'h7);
    cnt(16'h7);
    for (int v = 0; v < 4; v++) begin
      setup(32'hC | LD | 32'(v << 4), 16'hFFFF);
      rd(ADDR_COUNT);
      r0 = rdv;
      t0 = stamp;
      repeat (40) @(posedge ref_clk);
      rd(ADDR_COUNT);
      e = (stamp - t0) >> v;
      chk(32'(r0[31:16] - rdv[31:16]) - e + 1 <= 2, 1);
    end
    $display("reload and divide done");
  endtask : tReload
  // windows span a few crystal-derived periods; phase gives one either way
  task automatic tXtal();
    logic [15:0] r0;
    int w [4] = '{1250, 5000, 10000, 20000};
    int x [4] = '{4, 4, 4, 2};
    for (int k = 0; k < 4; k++) begin
      setup(LD | 32'(SRC_XTAL + 4'(k)), 16'hFFFF);
      rd(ADDR_COUNT);
      r0 = rdv[31:16];
      repeat (w[k]) @(posedge ref_clk);
      rd(ADDR_COUNT);
      chk(32'(r0 - rdv[31:16]) - 32'(x[k]) + 1 <= 2, 1);
    end
    $display("crystal sources done");
  endtask : tXtal
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    tBasic();
    tIrq();
    tReload();
    tXtal();
    closeOut();
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    fail();
  end
endmodule : tdct_timer_tb
`default_nettype wire
